// File: ccdt_pkg.sv
// constants for the sensor frame timing controller
package ccdt_pkg;
    // ===========================================
    // clock
    localparam int CLK_MHZ = 125;
    // ===========================================
    // array geometry
    localparam int LINES_ACTIVE = 1002;
    localparam int PIXELS_PER_LINE = 1004;
    localparam int DARK_LEFT_COLS = 28;
    localparam int DARK_RIGHT_COLS = 4;
    localparam int ISOLATION_LINES = 6;
    localparam int MULT_STAGES = 400;
    localparam int DISCARD_LINES = 2;
    // ===========================================
    // timing
    localparam int CLEAR_TIME_US = 100;
    localparam int CLEAR_CYCLES = CLEAR_TIME_US * CLK_MHZ;
    localparam int FRAME_RATE = 30;
    localparam int FRAME_CYCLES = (CLK_MHZ * 1000000) / FRAME_RATE;
    localparam int MIN_EXPOSURE_DIV = 5000;
    localparam int MIN_EXPOSURE_CYCLES = (CLK_MHZ * 1000000) / MIN_EXPOSURE_DIV;
    localparam int SETTLE_NS = 16;
    localparam int SETTLE_CYCLES = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int HALF_VERT = 4;
    localparam int HALF_HORZ = 2;
    // ===========================================
    // states
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_CLEAR = 7'h02,
        ST_INTEG = 7'h04,
        ST_XFER = 7'h08,
        ST_LINE = 7'h10,
        ST_PIX = 7'h20,
        ST_DONE = 7'h40
    } ccdt_state_e;
endpackage

// File: ccdt_ctrl.sv
// timing generator driving a frame-transfer multiplying image sensor
`timescale 1ns/1ps
`default_nettype none
// ===========================================
module ccdt_ctrl #(
    parameter int CLEAR_COUNT = ccdt_pkg::CLEAR_CYCLES,
    parameter int EXPOSURE_MAX = ccdt_pkg::FRAME_CYCLES,
    parameter int LINES = ccdt_pkg::LINES_ACTIVE + ccdt_pkg::ISOLATION_LINES
        + ccdt_pkg::DISCARD_LINES,
    parameter int PIXELS = ccdt_pkg::PIXELS_PER_LINE + ccdt_pkg::MULT_STAGES
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic START,
    input wire logic [23:0] EXPOSURE,
    input wire logic [3:0] LINE_SUM,
    input wire logic [3:0] PIXEL_SUM,
    output logic BUSY,
    output logic FRAME_DONE,
    output logic overflow_drain_bias,
    output logic image_area_phase_one,
    output logic image_area_phase_two,
    output logic storage_area_phase_one,
    output logic storage_area_phase_two,
    output logic serial_register_phase_one,
    output logic serial_register_phase_two,
    output logic multiplication_gate,
    output logic RESET_GATE,
    output logic SAMPLE,
    output logic LINE_VALID,
    output logic DARK_PIXEL
);
    localparam int CW = 24;

    ccdt_pkg::ccdt_state_e state;
    logic [CW-1:0] cnt;
    logic [15:0] line;
    logic [15:0] pix;
    logic [3:0] lsum;
    logic [3:0] psum;
    logic [3:0] phase;
    logic [CW-1:0] expo;
    logic start_s1, start_s2;

    function automatic logic [CW-1:0] clamp_exp(input logic [CW-1:0] e);
        if (e < CW'(ccdt_pkg::MIN_EXPOSURE_CYCLES))
            return CW'(ccdt_pkg::MIN_EXPOSURE_CYCLES);
        else if (e > CW'(EXPOSURE_MAX))
            return CW'(EXPOSURE_MAX);
        else
            return e;
    endfunction

    // ===========================================
    // start synchroniser
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            start_s1 <= 1'b0;
            start_s2 <= 1'b0;
        end else begin
            start_s1 <= START;
            start_s2 <= start_s1;
        end
    end

    // ===========================================
    // frame sequencer
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            state <= ccdt_pkg::ST_IDLE;
            cnt <= '0;
            line <= '0;
            pix <= '0;
            lsum <= '0;
            psum <= '0;
            phase <= '0;
            expo <= '0;
        end else begin
            case (state)
                ccdt_pkg::ST_IDLE: begin
                    cnt <= '0;
                    if (start_s2) begin
                        expo <= clamp_exp(EXPOSURE);
                        state <= ccdt_pkg::ST_CLEAR;
                    end
                end
                ccdt_pkg::ST_CLEAR: begin
                    if (cnt >= CW'(CLEAR_COUNT - 1)) begin
                        cnt <= '0;
                        state <= ccdt_pkg::ST_INTEG;
                    end else
                        cnt <= cnt + 1'b1;
                end
                ccdt_pkg::ST_INTEG: begin
                    if (cnt >= expo - 1'b1) begin
                        cnt <= '0;
                        line <= '0;
                        phase <= '0;
                        state <= ccdt_pkg::ST_XFER;
                    end else
                        cnt <= cnt + 1'b1;
                end
                ccdt_pkg::ST_XFER: begin
                    phase <= phase + 1'b1;
                    if (phase == 4'(2 * ccdt_pkg::HALF_VERT - 1)) begin
                        phase <= '0;
                        if (line == 16'(LINES - 1)) begin
                            line <= '0;
                            lsum <= '0;
                            state <= ccdt_pkg::ST_LINE;
                        end else
                            line <= line + 1'b1;
                    end
                end
                ccdt_pkg::ST_LINE: begin
                    phase <= phase + 1'b1;
                    if (phase == 4'(2 * ccdt_pkg::HALF_VERT - 1)) begin
                        phase <= '0;
                        lsum <= lsum + 1'b1;
                        line <= line + 1'b1;
                        if (lsum >= LINE_SUM || line == 16'(LINES - 1)) begin
                            lsum <= '0;
                            pix <= '0;
                            psum <= '0;
                            state <= ccdt_pkg::ST_PIX;
                        end
                    end
                end
                ccdt_pkg::ST_PIX: begin
                    phase <= phase + 1'b1;
                    if (phase == 4'(2 * ccdt_pkg::HALF_HORZ - 1)) begin
                        phase <= '0;
                        pix <= pix + 1'b1;
                        psum <= (psum >= PIXEL_SUM) ? 4'h0 : psum + 1'b1;
                        if (pix == 16'(PIXELS - 1)) begin
                            if (line >= 16'(LINES))
                                state <= ccdt_pkg::ST_DONE;
                            else
                                state <= ccdt_pkg::ST_LINE;
                        end
                    end
                end
                ccdt_pkg::ST_DONE: begin
                    state <= ccdt_pkg::ST_IDLE;
                end
                default: state <= ccdt_pkg::ST_IDLE;
            endcase
        end
    end

    // ===========================================
    // gate drives
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            overflow_drain_bias <= 1'b0;
            image_area_phase_one <= 1'b0;
            image_area_phase_two <= 1'b1;
            storage_area_phase_one <= 1'b0;
            storage_area_phase_two <= 1'b1;
            serial_register_phase_one <= 1'b0;
            serial_register_phase_two <= 1'b1;
            multiplication_gate <= 1'b0;
            RESET_GATE <= 1'b0;
        end else begin
            overflow_drain_bias <= (state == ccdt_pkg::ST_CLEAR);
            image_area_phase_one <= (state == ccdt_pkg::ST_XFER) &&
                (phase < 4'(ccdt_pkg::HALF_VERT));
            image_area_phase_two <= !((state == ccdt_pkg::ST_XFER) &&
                (phase < 4'(ccdt_pkg::HALF_VERT)));
            storage_area_phase_one <= (state == ccdt_pkg::ST_XFER ||
                state == ccdt_pkg::ST_LINE) && (phase < 4'(ccdt_pkg::HALF_VERT));
            storage_area_phase_two <= !((state == ccdt_pkg::ST_XFER ||
                state == ccdt_pkg::ST_LINE) && (phase < 4'(ccdt_pkg::HALF_VERT)));
            serial_register_phase_one <= (state == ccdt_pkg::ST_PIX) &&
                (phase < 4'(ccdt_pkg::HALF_HORZ));
            serial_register_phase_two <= !((state == ccdt_pkg::ST_PIX) &&
                (phase < 4'(ccdt_pkg::HALF_HORZ)));
            multiplication_gate <= (state == ccdt_pkg::ST_PIX) &&
                (phase >= 4'(ccdt_pkg::HALF_HORZ));
            RESET_GATE <= (state == ccdt_pkg::ST_PIX) && (phase == 4'h0) &&
                (psum == 4'h0);
        end
    end

    // ===========================================
    // readout qualifiers
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            SAMPLE <= 1'b0;
            LINE_VALID <= 1'b0;
            DARK_PIXEL <= 1'b0;
            BUSY <= 1'b0;
            FRAME_DONE <= 1'b0;
        end else begin
            // sample after the phase-one fall plus output settling
            SAMPLE <= (state == ccdt_pkg::ST_PIX) &&
                (phase == 4'(ccdt_pkg::HALF_HORZ + ccdt_pkg::SETTLE_CYCLES - 1)) &&
                (psum >= PIXEL_SUM);
            LINE_VALID <= (state == ccdt_pkg::ST_PIX) &&
                (line > 16'(ccdt_pkg::DISCARD_LINES + ccdt_pkg::ISOLATION_LINES));
            DARK_PIXEL <= (state == ccdt_pkg::ST_PIX) &&
                ((pix < 16'(ccdt_pkg::DARK_LEFT_COLS)) ||
                 (pix >= 16'(ccdt_pkg::PIXELS_PER_LINE - ccdt_pkg::DARK_RIGHT_COLS) &&
                  pix < 16'(ccdt_pkg::PIXELS_PER_LINE)));
            BUSY <= (state != ccdt_pkg::ST_IDLE);
            FRAME_DONE <= (state == ccdt_pkg::ST_DONE);
        end
    end
endmodule // ccdt_ctrl
`default_nettype wire

// File: ccdt_ctrl_asserts.sv
// checker for the sensor frame timing controller
`timescale 1ns/1ps
`default_nettype none
// ===========================================
// checker
module ccdt_chk #(
    parameter int CLEAR_COUNT = 8
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic BUSY,
    input wire logic FRAME_DONE,
    input wire logic overflow_drain_bias,
    input wire logic image_area_phase_one,
    input wire logic image_area_phase_two,
    input wire logic storage_area_phase_one,
    input wire logic storage_area_phase_two,
    input wire logic SAMPLE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    // length of the current drain pulse
    int run;
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) run <= 0;
        else run <= overflow_drain_bias ? run + 1 : 0;
    end
    property p_clear; $fell(overflow_drain_bias) |-> run >= CLEAR_COUNT; endproperty
    a_clear: assert property (p_clear) else $error("drain pulse too short");
    property p_start; $rose(BUSY) |-> ##[0:3] overflow_drain_bias; endproperty
    a_start: assert property (p_start) else $error("no drain pulse after start");
    property p_drain_busy; overflow_drain_bias |-> BUSY; endproperty
    a_drain_busy: assert property (p_drain_busy) else $error("drain pulse while idle");
    property p_integ; $fell(overflow_drain_bias) |-> $stable(image_area_phase_one) [*8]; endproperty
    a_integ: assert property (p_integ) else $error("transfer right after clear");
    property p_img; image_area_phase_one != image_area_phase_two; endproperty
    a_img: assert property (p_img) else $error("image phases overlap");
    property p_sto; storage_area_phase_one != storage_area_phase_two; endproperty
    a_sto: assert property (p_sto) else $error("storage phases overlap");
    property p_sample; SAMPLE |=> !SAMPLE; endproperty
    a_sample: assert property (p_sample) else $error("sample pulse too long");
    property p_sample_busy; SAMPLE |-> BUSY && !overflow_drain_bias; endproperty
    a_sample_busy: assert property (p_sample_busy) else $error("sample outside readout");
    property p_done; FRAME_DONE |=> !FRAME_DONE ##[0:1] !BUSY; endproperty
    a_done: assert property (p_done) else $error("frame end malformed");
    c_clear: cover property ($fell(overflow_drain_bias));
    c_sample: cover property (SAMPLE);
    c_done: cover property (FRAME_DONE);
endmodule // ccdt_chk
bind ccdt_ctrl ccdt_chk #(.CLEAR_COUNT(CLEAR_COUNT)) u_chk (.CLK(CLK), .NRST(NRST),
    .BUSY(BUSY), .FRAME_DONE(FRAME_DONE), .overflow_drain_bias(overflow_drain_bias),
    .image_area_phase_one(image_area_phase_one), .image_area_phase_two(image_area_phase_two),
    .storage_area_phase_one(storage_area_phase_one),
    .storage_area_phase_two(storage_area_phase_two), .SAMPLE(SAMPLE));
`default_nettype wire

// File: ccdt_sensor.sv
// behavioural model of the image sensor driven by the controller
`timescale 1ns/1ps
`default_nettype none
// ===========================================
// sensor model
module ccdt_sensor (
    input wire logic drain,
    input wire logic img_one,
    input wire logic srg_one,
    input wire logic rst_gate,
    output var int vshifts,
    output var int pixels,
    output var int resets,
    output var logic integrating
);
    initial integrating = 1'b0;
    // clearing pulse empties the wells and restarts counts
    always @(posedge drain) begin
        vshifts = 0;
        pixels = 0;
        resets = 0;
        integrating = 1'b0;
    end
    always @(negedge drain) integrating = 1'b1;
    // each image phase rise moves the frame one line toward storage
    always @(posedge img_one) begin
        vshifts = vshifts + 1;
        integrating = 1'b0;
    end
    always @(posedge srg_one) pixels = pixels + 1;
    always @(posedge rst_gate) resets = resets + 1;
endmodule // ccdt_sensor
`default_nettype wire

// File: testbench.sv
// self-checking bench for the sensor frame timing controller
`timescale 1ns/1ps
`default_nettype none
// ===========================================
// bench
module testbench;
    localparam int LN = 4;
    localparam int PX = 6;
    typedef struct {logic [3:0] ls; logic [3:0] ps; int smp; int spx;} ccdt_row_s;
    ccdt_row_s rows [2] = '{'{4'h0, 4'h0, LN * PX, LN * PX}, '{4'h1, 4'h2, 4, 12}};
    logic clk = 1'b0, nrst = 1'b0, start = 1'b0;
    logic [23:0] expo = 24'h0061A8;
    logic [3:0] lsum = 4'h0, psum = 4'h0;
    logic busy, done, drain, ia1, ia2, sa1, sa2, sr1, sr2, mg, rg, smp, lv, dk, integ;
    int vs, px, rs, samples, bad_count = 0, total_checks = 0;
    int dark_samples, valid_samples, mg_cycles;
    always #4 clk = ~clk;
    // readout qualifier and multiplication gate tallies
    always @(posedge clk) begin
        if (smp === 1'b1) samples++;
        if (smp === 1'b1 && dk === 1'b1) dark_samples++;
        if (lv === 1'b1) valid_samples++;
        if (mg === 1'b1) mg_cycles++;
    end
    ccdt_ctrl #(.CLEAR_COUNT(8), .EXPOSURE_MAX(30000), .LINES(LN), .PIXELS(PX)) dut (
        .CLK(clk), .NRST(nrst), .START(start), .EXPOSURE(expo), .LINE_SUM(lsum),
        .PIXEL_SUM(psum), .BUSY(busy), .FRAME_DONE(done), .overflow_drain_bias(drain),
        .image_area_phase_one(ia1), .image_area_phase_two(ia2), .storage_area_phase_one(sa1),
        .storage_area_phase_two(sa2), .serial_register_phase_one(sr1),
        .serial_register_phase_two(sr2), .multiplication_gate(mg), .RESET_GATE(rg),
        .SAMPLE(smp), .LINE_VALID(lv), .DARK_PIXEL(dk));
    ccdt_sensor u_sensor (.drain(drain), .img_one(ia1), .srg_one(sr1), .rst_gate(rg),
        .vshifts(vs), .pixels(px), .resets(rs), .integrating(integ));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // bounded wait for done (sel 0) or drain (sel 1) to reach a level
    task automatic wait_for(input int sel, input logic lvl, input int lim);
        int n;
        n = 0;
        while (((sel == 0) ? done : drain) !== lvl && n < lim) begin
            @(negedge clk);
            n++;
        end
        if (n >= lim) begin
            bad_count++;
            close_out();
        end
    endtask
    initial begin
        repeat (4) @(negedge clk);
        check("reset_levels", {busy, done, drain, ia1, ia2, sa1, sa2, sr1, sr2, mg, rg, smp,
            lv, dk}, 14'h2A0);
        $display("test reset done");
        nrst = 1'b1;
        foreach (rows[i]) begin
            lsum = rows[i].ls;
            psum = rows[i].ps;
            samples = 0;
            dark_samples = 0;
            valid_samples = 0;
            mg_cycles = 0;
            start = 1'b1;
            repeat (40) @(negedge clk);
            start = 1'b0;
            wait_for(0, 1'b1, 40000);
            check("vshifts", vs, LN);
            check("serial_pixels", px, rows[i].spx);
            check("samples", samples, rows[i].smp);
            check("resets", rs, rows[i].smp);
            check("dark_samples", dark_samples, rows[i].smp);
            check("valid_lines", valid_samples, 0);
            check("mult_cycles", mg_cycles, rows[i].spx * ccdt_pkg::HALF_HORZ);
            repeat (10) @(negedge clk);
            check("busy_after_held_start", busy, 1'b0);
            $display("test row %0d done", i);
        end
        start = 1'b1;
        wait_for(1, 1'b1, 20);
        start = 1'b0;
        wait_for(1, 1'b0, 20);
        repeat (100) @(negedge clk);
        check("integrating", integ, 1'b1);
        check("no_early_transfer", vs, 0);
        nrst = 1'b0;
        @(negedge clk);
        check("midrun_reset", {busy, drain, ia1, ia2, sa2, sr2, smp}, 7'h0E);
        $display("test abort done");
        close_out();
    end
endmodule // testbench
`default_nettype wire
